// ### include/led_dim_pkg.sv
// package for the per-channel dimming register bank: offsets, field layouts,
// reset values, pwm period and the register request/answer carriers.
// assumes one register clock shared by the serial engine and this bank.
package led_dim_pkg;

    // ==========================================================
    // register offsets (one byte address per register)
    localparam logic [7:0] ADDR_CH2_DUTY_HIGH = 8'h0f;
    localparam logic [7:0] ADDR_CH3_CURRENT_CODE = 8'h10;
    localparam logic [7:0] ADDR_CH3_DUTY_LOW = 8'h11;
    localparam logic [7:0] ADDR_CH3_DUTY_HIGH = 8'h12;
    localparam logic [7:0] ADDR_CH4_CURRENT_CODE = 8'h13;
    localparam logic [7:0] ADDR_CH4_DUTY_LOW = 8'h14;
    localparam logic [7:0] ADDR_CH4_DUTY_HIGH = 8'h15;
    localparam logic [7:0] ADDR_CH5_CURRENT_CODE = 8'h16;
    localparam logic [7:0] ADDR_CH5_DUTY_LOW = 8'h17;
    localparam logic [7:0] ADDR_CH5_DUTY_HIGH = 8'h18;
    localparam logic [7:0] ADDR_CH6_CURRENT_CODE = 8'h19;

    // ==========================================================
    // field widths and positions
    localparam int CODE_W = 6;          // current code, bits 5:0
    localparam int LOWER_W = 4;         // duty bits 3:0 in the low register
    localparam int UPPER_W = 8;         // duty bits 11:4 in the high register
    localparam int DUTY_W = 12;
    localparam int DATA_W = 8;
    localparam int CODE_FULL_SCALE = 63; // led current = code / 63 * set current

    // ==========================================================
    // reset values: full current and full duty
    localparam logic [CODE_W-1:0] CODE_RST = 6'h3f;
    localparam logic [LOWER_W-1:0] LOWER_RST = 4'hf;
    localparam logic [UPPER_W-1:0] UPPER_RST = 8'hff;
    localparam logic [DUTY_W-1:0] DUTY_RST = 12'hfff;

    // ==========================================================
    // pwm period: 4096 steps of the free-running counter
    localparam int PWM_STEPS = 4096;

    // ==========================================================
    // register port carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } reg_rsp_s;

endpackage

// ### rtl/duty_channel.sv
// one channel's duty path: upper byte storage, applied duty and on-time compare.
// assumes the low nibble is held by the caller and the pwm counter is shared.
module duty_channel (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic upper_we,
    input wire logic [led_dim_pkg::UPPER_W-1:0] wdata,
    input wire logic [led_dim_pkg::LOWER_W-1:0] lower,
    input wire logic [led_dim_pkg::DUTY_W-1:0] pwm_count,
    output logic [led_dim_pkg::UPPER_W-1:0] upper,
    output logic [led_dim_pkg::DUTY_W-1:0] duty,
    output logic dim_on
);

    // ==========================================================
    // storage: the applied duty moves only on a high-byte write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            upper <= led_dim_pkg::UPPER_RST;  // RL6
            duty <= led_dim_pkg::DUTY_RST;    // RL6
        end else if (ce && upper_we) begin
            upper <= wdata;                   // RL3
            duty <= {wdata, lower};           // RL4
        end
    end

    // on while the counter is below the duty; full scale leaves one dark step
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dim_on <= 1'b0;
        end else if (ce) begin
            dim_on <= (pwm_count < duty);     // RL7
        end
    end

endmodule

// ### rtl/led_dim_regs.sv
// dimming register bank for channel 2 (high byte) through channel 6 (current).
// assumes the serial engine issues one-cycle read/write strobes on ref_clk.
// Functional notes
// RL1 - Each channel keeps a 6-bit current code in bits 5:0, reset to all ones, scaling current by code/63.
// RL2 - Each low duty register holds duty bits 3:0 in its bits 3:0 and reads zero in bits 7:4.
// RL3 - Each high duty register holds duty bits 11:4 in all eight bits.
// RL4 - Writing only the low register leaves the applied duty alone; a high write applies all 12 bits.
// RL5 - Each channel uses three consecutive addresses: current code, low duty, high duty.
// RL6 - After reset the low field is 1111 and the high field 11111111, so duty starts at full.
// RL7 - Each applied duty is compared to a free-running 4096-step counter to give the on-time.
module led_dim_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire led_dim_pkg::reg_req_s reg_req,
    output led_dim_pkg::reg_rsp_s reg_rsp,
    input wire logic [led_dim_pkg::LOWER_W-1:0] ch2_duty_lower,
    output logic [led_dim_pkg::CODE_W-1:0] ch3_current_code,
    output logic [led_dim_pkg::CODE_W-1:0] ch4_current_code,
    output logic [led_dim_pkg::CODE_W-1:0] ch5_current_code,
    output logic [led_dim_pkg::CODE_W-1:0] ch6_current_code,
    output logic [led_dim_pkg::DUTY_W-1:0] ch2_duty,
    output logic [led_dim_pkg::DUTY_W-1:0] ch3_duty,
    output logic [led_dim_pkg::DUTY_W-1:0] ch4_duty,
    output logic [led_dim_pkg::DUTY_W-1:0] ch5_duty,
    output logic [3:0] dim_on
);

    // ==========================================================
    // address decode
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic sel_c3;
    logic sel_c4;
    logic sel_c5;
    logic sel_c6;
    logic sel_l3;
    logic sel_l4;
    logic sel_l5;
    logic sel_h2;
    logic sel_h3;
    logic sel_h4;
    logic sel_h5;
    logic wr_h2;
    logic wr_h3;
    logic wr_h4;
    logic wr_h5;

    // write and read share the decode; strobes only count while ce is high
    assign wr = reg_req.wr && ce;
    assign rd = reg_req.rd && ce;
    assign addr = reg_req.addr;
    assign wdata = reg_req.wdata;

    // three consecutive addresses per channel
    assign sel_h2 = (addr == led_dim_pkg::ADDR_CH2_DUTY_HIGH);    // RL5
    assign sel_c3 = (addr == led_dim_pkg::ADDR_CH3_CURRENT_CODE); // RL5
    assign sel_l3 = (addr == led_dim_pkg::ADDR_CH3_DUTY_LOW);     // RL5
    assign sel_h3 = (addr == led_dim_pkg::ADDR_CH3_DUTY_HIGH);    // RL5
    assign sel_c4 = (addr == led_dim_pkg::ADDR_CH4_CURRENT_CODE);
    assign sel_l4 = (addr == led_dim_pkg::ADDR_CH4_DUTY_LOW);
    assign sel_h4 = (addr == led_dim_pkg::ADDR_CH4_DUTY_HIGH);
    assign sel_c5 = (addr == led_dim_pkg::ADDR_CH5_CURRENT_CODE);
    assign sel_l5 = (addr == led_dim_pkg::ADDR_CH5_DUTY_LOW);
    assign sel_h5 = (addr == led_dim_pkg::ADDR_CH5_DUTY_HIGH);
    assign sel_c6 = (addr == led_dim_pkg::ADDR_CH6_CURRENT_CODE);

    // high-byte write enables, one per duty channel
    assign wr_h2 = wr && sel_h2;                                  // RL4
    assign wr_h3 = wr && sel_h3;                                  // RL4
    assign wr_h4 = wr && sel_h4;
    assign wr_h5 = wr && sel_h5;

    // ==========================================================
    // current codes: bits 7:6 are not stored, the analog stage scales by code/63
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch3_current_code <= led_dim_pkg::CODE_RST;           // RL1
            ch4_current_code <= led_dim_pkg::CODE_RST;
            ch5_current_code <= led_dim_pkg::CODE_RST;
            ch6_current_code <= led_dim_pkg::CODE_RST;
        end else if (wr) begin
            if (sel_c3) ch3_current_code <= wdata[5:0];          // RL1
            if (sel_c4) ch4_current_code <= wdata[5:0];
            if (sel_c5) ch5_current_code <= wdata[5:0];
            if (sel_c6) ch6_current_code <= wdata[5:0];
        end
    end

    // ==========================================================
    // low duty nibbles: stored but not applied until the high byte lands
    logic [led_dim_pkg::LOWER_W-1:0] ch3_duty_lower;
    logic [led_dim_pkg::LOWER_W-1:0] ch4_duty_lower;
    logic [led_dim_pkg::LOWER_W-1:0] ch5_duty_lower;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch3_duty_lower <= led_dim_pkg::LOWER_RST;            // RL6
            ch4_duty_lower <= led_dim_pkg::LOWER_RST;
            ch5_duty_lower <= led_dim_pkg::LOWER_RST;
        end else if (wr) begin
            if (sel_l3) ch3_duty_lower <= wdata[3:0];            // RL2
            if (sel_l4) ch4_duty_lower <= wdata[3:0];
            if (sel_l5) ch5_duty_lower <= wdata[3:0];
        end
    end

    // ==========================================================
    // free-running pwm period counter, wraps every 4096 steps
    logic [led_dim_pkg::DUTY_W-1:0] pwm_count;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_count <= 12'h000;
        end else if (ce) begin
            pwm_count <= pwm_count + 12'h001;                    // RL7
        end
    end

    // ==========================================================
    // duty channels 2..5; channel 2 low nibble lives outside this bank
    logic [led_dim_pkg::UPPER_W-1:0] ch2_duty_upper;
    logic [led_dim_pkg::UPPER_W-1:0] ch3_duty_upper;
    logic [led_dim_pkg::UPPER_W-1:0] ch4_duty_upper;
    logic [led_dim_pkg::UPPER_W-1:0] ch5_duty_upper;

    duty_channel u_ch2 (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .upper_we(wr_h2),
        .wdata(wdata),
        .lower(ch2_duty_lower),
        .pwm_count(pwm_count),
        .upper(ch2_duty_upper),
        .duty(ch2_duty),
        .dim_on(dim_on[0])
    );

    duty_channel u_ch3 (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .upper_we(wr_h3),
        .wdata(wdata),
        .lower(ch3_duty_lower),
        .pwm_count(pwm_count),
        .upper(ch3_duty_upper),
        .duty(ch3_duty),
        .dim_on(dim_on[1])
    );

    duty_channel u_ch4 (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .upper_we(wr_h4),
        .wdata(wdata),
        .lower(ch4_duty_lower),
        .pwm_count(pwm_count),
        .upper(ch4_duty_upper),
        .duty(ch4_duty),
        .dim_on(dim_on[2])
    );

    duty_channel u_ch5 (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .upper_we(wr_h5),
        .wdata(wdata),
        .lower(ch5_duty_lower),
        .pwm_count(pwm_count),
        .upper(ch5_duty_upper),
        .duty(ch5_duty),
        .dim_on(dim_on[3])
    );

    // ==========================================================
    // read mux: reserved bits and unmapped addresses read as zero
    logic [7:0] rd_mux;

    assign rd_mux =
        sel_h2 ? ch2_duty_upper :                               // RL3
        sel_c3 ? {2'b00, ch3_current_code} :
        sel_l3 ? {4'h0, ch3_duty_lower} :                       // RL2
        sel_h3 ? ch3_duty_upper :
        sel_c4 ? {2'b00, ch4_current_code} :
        sel_l4 ? {4'h0, ch4_duty_lower} :
        sel_h4 ? ch4_duty_upper :
        sel_c5 ? {2'b00, ch5_current_code} :
        sel_l5 ? {4'h0, ch5_duty_lower} :
        sel_h5 ? ch5_duty_upper :
        sel_c6 ? {2'b00, ch6_current_code} :
        8'h00;

    // answer registered one cycle after the read strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rsp <= '0;
        end else if (ce) begin
            reg_rsp.valid <= rd;
            reg_rsp.data <= rd ? rd_mux : reg_rsp.data;
        end
    end

    // ==========================================================
    // assertions; read checks use the pre-edge value since a write may share the cycle
    property p_code_write;
        @(posedge ref_clk) disable iff (rst)
        (wr && sel_c3) |=> (ch3_current_code == $past(wdata[5:0]));
    endproperty
    a_code_write: assert property (p_code_write) else $error("current code not stored"); // RL1

    property p_lower_read;
        @(posedge ref_clk) disable iff (rst)
        (rd && sel_l4) |=> (reg_rsp.valid && reg_rsp.data[7:4] == 4'h0
                            && reg_rsp.data[3:0] == $past(ch4_duty_lower));
    endproperty
    a_lower_read: assert property (p_lower_read) else $error("low duty read wrong"); // RL2

    property p_upper_apply;
        @(posedge ref_clk) disable iff (rst)
        (wr && sel_h3) |=> (ch3_duty == {$past(wdata), $past(ch3_duty_lower)});
    endproperty
    a_upper_apply: assert property (p_upper_apply) else $error("high write not applied"); // RL3

    property p_low_holds;
        @(posedge ref_clk) disable iff (rst)
        (wr && sel_l5) |=> $stable(ch5_duty);
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("low write moved duty"); // RL4

    property p_addr_map;
        @(posedge ref_clk) disable iff (rst)
        (rd && sel_h4) |=> (reg_rsp.valid && reg_rsp.data == $past(ch4_duty_upper));
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("high duty address wrong"); // RL5

    property p_reset_vals;
        @(posedge ref_clk)
        rst |=> (ch2_duty == 12'hfff && ch5_duty == 12'hfff && ch6_current_code == 6'h3f);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong"); // RL6

    property p_pwm_on;
        @(posedge ref_clk) disable iff (rst)
        ce |=> (dim_on[1] == ($past(pwm_count) < $past(ch3_duty)));
    endproperty
    a_pwm_on: assert property (p_pwm_on) else $error("on-time compare wrong"); // RL7

    property p_count_step;
        @(posedge ref_clk) disable iff (rst)
        ce |=> (pwm_count == $past(pwm_count) + 12'h001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("pwm counter stalled"); // RL7

    c_low_then_high: cover property (@(posedge ref_clk) disable iff (rst)
        (wr && sel_l3) ##[1:20] (wr && sel_h3));
    c_unmapped_read: cover property (@(posedge ref_clk) disable iff (rst)
        rd && addr == 8'h1a);
    c_pwm_wrap: cover property (@(posedge ref_clk) disable iff (rst)
        ce && pwm_count == 12'hfff);

endmodule

// ### testbench/host_model.sv
// host-side model of the serial engine that issues register strobes.
// assumes the bank answers a read with reg_rsp.valid one cycle after the strobe.
module host_model (
    input wire logic ref_clk,
    output logic ce,
    output led_dim_pkg::reg_req_s reg_req,
    input wire led_dim_pkg::reg_rsp_s reg_rsp
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // idle state: no strobe, clock enabled
    initial begin
        ce = 1'b1;
        reg_req = '0;
    end

    // one strobe cycle; address and data are scrambled once the strobe is gone
    // so that a bank which samples late sees garbage, not the old value
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_req.wr = w;
        reg_req.rd = ~w;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // callers must write the low part of a duty before the high part, which applies both
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask

    // clock enable is owned here so that only one process drives it
    task automatic set_ce(input logic v);
        ce = v;
    endtask

    // bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        put(1'b0, a, 8'h00);
        ok = 0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rsp.valid === 1'b1) begin
                d = reg_rsp.data;
                ok = 1;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the dimming register bank against a queue-free
// integer model; assumes the host model above drives the register port.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk;
    logic rst;
    logic ce;
    logic [3:0] ch2_lo;
    led_dim_pkg::reg_req_s reg_req;
    led_dim_pkg::reg_rsp_s reg_rsp;
    logic [5:0] c3, c4, c5, c6;
    logic [11:0] d2, d3, d4, d5;
    logic [3:0] dim_on;
    int n_errors = 0;
    int num_checks = 0;
    int rm[int];
    int dm[4];

    // ==========================================================
    // clock, design and host
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    led_dim_regs i_led_dim_regs (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .ch2_duty_lower(ch2_lo), .ch3_current_code(c3),
        .ch4_current_code(c4), .ch5_current_code(c5), .ch6_current_code(c6),
        .ch2_duty(d2), .ch3_duty(d3), .ch4_duty(d4), .ch5_duty(d5), .dim_on(dim_on));
    host_model i_host_model (.ref_clk(ref_clk), .ce(ce), .reg_req(reg_req),
        .reg_rsp(reg_rsp));

    // ==========================================================
    // model: writable bits equal the reset value of each register
    function automatic int fmask(int a);
        if ((a - 8'h0f) % 3 == 0) return 8'hff;
        if ((a - 8'h10) % 3 == 0) return 8'h3f;
        return 8'h0f;
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset pulse of four cycles, model restored to the table values
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        for (int a = 8'h0f; a <= 8'h19; a++) rm[a] = fmask(a);
        for (int k = 0; k < 4; k++) dm[k] = 12'hfff;
    endtask

    // compare every current code and duty output against the model, and read back one register
    task automatic sweep(int a);
        logic [7:0] d;
        bit ok;
        logic [23:0] codes;
        logic [47:0] duties;
        codes = {c6, c5, c4, c3};
        duties = {d5, d4, d3, d2};
        for (int k = 0; k < 4; k++) begin
            check("code", 16'(codes[k*6 +: 6]), 16'(rm[8'h10 + 3*k]));
            check("duty", 16'(duties[k*12 +: 12]), 16'(dm[k]));
        end
        i_host_model.rd(8'(a), d, ok);
        if (!ok) begin
            n_errors++;
            close_out();
        end
        check("readback", 16'(d), rm.exists(a) ? 16'(rm[a]) : 16'h0000);
    endtask

    task automatic wr_model(int a, logic [7:0] d);
        int k;
        i_host_model.wr(8'(a), d);
        if (!rm.exists(a)) return;
        rm[a] = d & fmask(a);
        k = (a - 8'h0f) / 3;
        if ((a - 8'h0f) % 3 == 0) dm[k] = {d, (k == 0) ? ch2_lo : 4'(rm[a - 1])};
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int a;
        int on[4];
        rst = 1'b1;
        ch2_lo = 4'h0;
        void'($urandom(37));
        do_reset();
        for (a = 8'h0f; a <= 8'h1a; a++) sweep(a);
        $display("test reset values done");
        for (int i = 0; i < 60; i++) begin
            a = 8'h0f + $urandom_range(10);
            ch2_lo = 4'($urandom);
            wr_model(a, 8'($urandom));
            sweep(a);
        end
        wr_model(8'h1a, 8'h55);
        sweep(8'h1a);
        $display("test random access done");
        i_host_model.set_ce(1'b0);
        i_host_model.wr(8'h12, 8'h00);
        i_host_model.set_ce(1'b1);
        sweep(8'h12);
        $display("test frozen clock enable done");
        wr_model(8'h11, 8'h05);
        sweep(8'h11);
        wr_model(8'h12, 8'h01);
        wr_model(8'h0f, 8'h80);
        on = '{0, 0, 0, 0};
        for (int i = 0; i < 4096; i++) begin
            @(posedge ref_clk);
            #1;
            for (int k = 0; k < 4; k++) on[k] += dim_on[k];
        end
        check("ch2 on time", 16'(on[0]), 16'(dm[0]));
        check("ch3 on time", 16'(on[1]), 16'h0015);
        check("ch4 on time", 16'(on[2]), 16'(dm[2]));
        check("ch5 on time", 16'(on[3]), 16'(dm[3]));
        $display("test pwm on time done");
        do_reset();
        for (a = 8'h0f; a <= 8'h19; a++) sweep(a);
        $display("test second reset done");
        close_out();
    end

    // watchdog against a hung run
    initial begin
        #250us;
        n_errors++;
        close_out();
    end
endmodule
